/* File: qpdio_pkg.sv */
package qpdio_pkg;
	// ==========================================
	// register indices (word offsets, scaled by four on the bus)
	localparam logic [2:0] IDX_PORT_A_DATA  = 3'h0;
	localparam logic [2:0] IDX_PORT_D_DATA  = 3'h3;
	localparam logic [2:0] IDX_PORT_DIR     = 3'h4;
	localparam logic [2:0] IDX_IRQ_CTRL     = 3'h5;
	localparam logic [2:0] IDX_SPARE_ZERO_A = 3'h6;
	localparam logic [2:0] IDX_SPARE_ZERO_B = 3'h7;
	localparam logic [4:0] IDX_IRQ_STATUS   = 5'h08;
	localparam logic [4:0] IDX_IRQ_CLEAR    = 5'h09;
	localparam logic [4:0] IDX_IRQ_ENABLE   = 5'h0a;
	localparam int         ADDR_W           = 7;
	// ==========================================
	// field positions
	localparam int IRQ_ENABLE_BIT  = 7;
	localparam int IRQ_PENDING_BIT = 6;
	localparam int NUM_PORTS       = 4;
	localparam int PORT_W          = 8;
	// ==========================================
	// reset values and bus response codes
	localparam logic [7:0]  PORT_DATA_RST = 8'h00;
	localparam logic [3:0]  DIR_RST       = 4'h0;
	localparam logic [1:0]  MODE_RST      = 2'h0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		QPDIO_LOW_LEVEL  = 2'h0,
		QPDIO_HIGH_LEVEL = 2'h1,
		QPDIO_FALL_EDGE  = 2'h2,
		QPDIO_RISE_EDGE  = 2'h3
	} qpdio_mode_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} qpdio_rd_t;
endpackage

/* File: qpdio_top.sv */
`timescale 1ns/1ps
// What this block does
// (RULE1) an input port reads back the level on its pins, high as 1 and low as 0.
// (RULE2) an output port reads back its output register, the value on its pins.
// (RULE3) each port has its own output register, written in any direction and kept.
// (RULE4) software presets an output by writing data while input, then turning it to output.
// (RULE5) outputs are active high, a 1 drives the pin high and a 0 drives it low.
// (RULE6) the four port data registers sit at offsets zero to three and are read/write.
// (RULE7) offset four holds one direction bit per port, A in bit 0, 1 meaning output.
// (RULE8) reset clears every direction bit so all ports start as inputs.
// (RULE9) the only interrupt source is port A line 0.
// (RULE10) bits 1:0 at offset five pick low level, high level, falling or rising edge.
// (RULE11) bit 7 at offset five enables the interrupt and is cleared by reset.
// (RULE12) bit 6 at offset five reads 1 while pending, and that read clears it.
// (RULE13) software disables the interrupt before changing the mode.
// (RULE14) in level modes pending cannot clear until the source input has changed.
// (RULE15) the interrupt request is high while pending and enabled.
// (RULE16) unused bits at offsets four and five, and offsets six and seven, read zero.
module qpdio_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [6:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [6:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// port pins, one byte per port, A in the low byte
	input  wire logic [31:0] pins_i,
	output logic [31:0]      pins_o,
	output logic [31:0]      pins_oe,
	// interrupt
	output logic             irq
);
	// ==========================================
	// state
	logic [7:0]  port_q [4];
	logic [3:0]  dir_q;
	logic [1:0]  mode_q;
	logic        irq_en_q;
	logic        pend_q;
	logic        src_prev_q;
	logic        sts_q;
	logic        sts_en_q;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [6:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wlane0_q;

	// ==========================================
	// helpers
	function automatic logic [4:0] word_idx(input logic [6:0] a);
		return a[6:2];
	endfunction

	function automatic logic [7:0] port_view(input logic [7:0] pin, input logic [7:0] reg_v,
	                                         input logic dir);
		return dir ? reg_v : pin; // RULE1 RULE2
	endfunction

	// ==========================================
	// write channel: address and data taken in either order
	logic do_wr;
	logic do_rd;
	logic [4:0] widx;
	logic [4:0] ridx;
	logic       src;
	logic       cond;
	logic       rd_pend;
	assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign widx  = word_idx(awaddr_q);
	assign src   = pins_i[0]; // RULE9

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 7'h00;
			wdata_q       <= 32'h0000_0000;
			wlane0_q      <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= qpdio_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wlane0_q <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (widx > qpdio_pkg::IDX_IRQ_ENABLE) ?
				                qpdio_pkg::RESP_SLVERR : qpdio_pkg::RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// port data and direction
	genvar g;
	generate
		for (g = 0; g < qpdio_pkg::NUM_PORTS; g++) begin : g_port
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					port_q[g] <= qpdio_pkg::PORT_DATA_RST;
				end else if (do_wr && wlane0_q && widx == 5'(g)) begin
					port_q[g] <= wdata_q[7:0]; // RULE3 RULE6
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pins_o[g*8 +: 8]  <= 8'h00;
					pins_oe[g*8 +: 8] <= 8'h00;
				end else begin
					pins_o[g*8 +: 8]  <= port_q[g]; // RULE5
					pins_oe[g*8 +: 8] <= {8{dir_q[g]}}; // RULE4
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_q <= qpdio_pkg::DIR_RST; // RULE8
		end else if (do_wr && wlane0_q && widx == 5'(qpdio_pkg::IDX_PORT_DIR)) begin
			dir_q <= wdata_q[3:0]; // RULE7
		end
	end

	// ==========================================
	// interrupt control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q   <= qpdio_pkg::MODE_RST;
			irq_en_q <= 1'b0; // RULE11
		end else if (do_wr && wlane0_q && widx == 5'(qpdio_pkg::IDX_IRQ_CTRL)) begin
			mode_q   <= wdata_q[1:0]; // RULE10 RULE13
			irq_en_q <= wdata_q[qpdio_pkg::IRQ_ENABLE_BIT];
		end
	end

	always_comb begin
		case (qpdio_pkg::qpdio_mode_t'(mode_q))
			qpdio_pkg::QPDIO_LOW_LEVEL:  cond = !src;
			qpdio_pkg::QPDIO_HIGH_LEVEL: cond = src;
			qpdio_pkg::QPDIO_FALL_EDGE:  cond = src_prev_q && !src;
			qpdio_pkg::QPDIO_RISE_EDGE:  cond = !src_prev_q && src;
			default:                     cond = 1'b0;
		endcase
	end

	assign do_rd   = s_axi_arvalid && s_axi_arready;
	assign ridx    = word_idx(s_axi_araddr);
	assign rd_pend = do_rd && ridx == 5'(qpdio_pkg::IDX_IRQ_CTRL);

	// level modes: set wins over the clearing read while the level holds,
	// so only a read after the input has let go clears pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_prev_q <= 1'b1; // pull-up idle, no false rise after reset
			pend_q     <= 1'b0;
		end else begin
			src_prev_q <= src;
			if (cond && irq_en_q) begin
				pend_q <= 1'b1; // RULE12 RULE14
			end else if (rd_pend) begin
				pend_q <= 1'b0; // RULE12
			end
		end
	end

	// sticky status, clear-on-write and enable mirror of the pending event
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_q    <= 1'b0;
			sts_en_q <= 1'b0;
		end else begin
			if (!pend_q && cond && irq_en_q) begin
				sts_q <= 1'b1;
			end else if (do_wr && wlane0_q && widx == qpdio_pkg::IDX_IRQ_CLEAR && wdata_q[0]) begin
				sts_q <= 1'b0;
			end
			if (do_wr && wlane0_q && widx == qpdio_pkg::IDX_IRQ_ENABLE) begin
				sts_en_q <= wdata_q[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (pend_q && irq_en_q) || (sts_q && sts_en_q); // RULE15
		end
	end

	// ==========================================
	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= qpdio_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (do_rd) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= qpdio_pkg::RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000; // RULE16
				if (ridx <= 5'(qpdio_pkg::IDX_PORT_D_DATA)) begin
					s_axi_rdata[7:0] <= port_view(pins_i[ridx[1:0]*8 +: 8], port_q[ridx[1:0]],
					                              dir_q[ridx[1:0]]);
				end else if (ridx == 5'(qpdio_pkg::IDX_PORT_DIR)) begin
					s_axi_rdata[3:0] <= dir_q;
				end else if (ridx == 5'(qpdio_pkg::IDX_IRQ_CTRL)) begin
					s_axi_rdata[7:0] <= {irq_en_q, pend_q, 4'h0, mode_q};
				end else if (ridx == qpdio_pkg::IDX_IRQ_STATUS) begin
					s_axi_rdata[0] <= sts_q;
				end else if (ridx == qpdio_pkg::IDX_IRQ_ENABLE) begin
					s_axi_rdata[0] <= sts_en_q;
				end else if (ridx > qpdio_pkg::IDX_IRQ_ENABLE) begin
					s_axi_rresp <= qpdio_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // qpdio_top

/* File: qpdio_field_model.sv */
`timescale 1ns/1ps
// ==========
// cable-side devices, a pull-up on every line
module qpdio_field_model (
	// device side
	input  wire logic [31:0] pins_o,
	input  wire logic [31:0] pins_oe,
	// field side
	input  wire logic [31:0] field_drv,
	input  wire logic [31:0] field_en,
	output logic      [31:0] pins_i
);
	// released lines float high, never hold the last value
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			pins_i[i] = pins_oe[i] ? pins_o[i] : (field_en[i] ? field_drv[i] : 1'b1);
		end
	end
endmodule // qpdio_field_model

/* File: qpdio_top_sva.sv */
`timescale 1ns/1ps
// ==========
// bus and pin checks
module qpdio_top_sva (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [6:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pins
	input wire logic [31:0] pins_o,
	input wire logic [31:0] pins_oe,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_aw_take; s_axi_awvalid && s_axi_awready; endsequence
	a_reset_idle: assert property ($rose(aresetn) |-> pins_oe == 32'h0 && !irq)
		else $error("outputs not idle after reset");
	a_oe_by_port: assert property (pins_oe == {{8{pins_oe[24]}}, {8{pins_oe[16]}},
		{8{pins_oe[8]}}, {8{pins_oe[0]}}}) else $error("direction split inside a port");
	a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	a_write_answer: assert property (s_aw_take |-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
	a_spare_zero: assert property (s_ar_take ##0 s_axi_araddr[6:3] == 4'h3 |=>
		s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0) else $error("spare register not zero");
	a_ar_pulse: assert property (s_ar_take |=> !s_axi_arready)
		else $error("address ready held");
	// output register moves only through a write, answered the cycle before
	a_pins_o_quiet: assert property ($changed(pins_o) |-> $past(s_axi_bvalid))
		else $error("pin outputs changed without a write");
endmodule // qpdio_top_sva
bind qpdio_top qpdio_top_sva qpdio_top_sva_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_o, .pins_oe, .irq);

/* File: test_quad_port_digital_io.sv */
`timescale 1ns/1ps
module test_quad_port_digital_io;
	typedef struct packed {logic wr; logic [6:0] addr; logic [31:0] data;} qpdio_row_t;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [6:0]        s_axi_awaddr = 7'h0, s_axi_araddr = 7'h0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0]       s_axi_wdata = 32'h0, field_drv = 32'h3c00_00a5, field_en = 32'hffff_ffff;
	logic [3:0]        s_axi_wstrb = 4'hf;
	wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire logic [1:0]   s_axi_bresp, s_axi_rresp;
	wire logic [31:0]  s_axi_rdata, pins_i, pins_o, pins_oe;
	int                n_mismatch = 0, comparisons = 0, cycles = 0;
	logic [31:0]       got;
	logic [1:0]        resp, md;
	qpdio_row_t        rows [9] = '{'{1'b0, 7'h00, 32'ha5}, '{1'b0, 7'h0c, 32'h3c},
		'{1'b1, 7'h04, 32'h5a}, '{1'b1, 7'h10, 32'hf6}, '{1'b0, 7'h10, 32'h06},
		'{1'b0, 7'h04, 32'h5a}, '{1'b1, 7'h18, 32'hff}, '{1'b0, 7'h18, 32'h0}, '{1'b0, 7'h1c, 32'h0}};
	qpdio_top qpdio_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pins_i, .pins_o, .pins_oe, .irq);
	qpdio_field_model qpdio_field_model_inst (.pins_o, .pins_oe, .field_drv, .field_en, .pins_i);
	always #10 aclk = ~aclk;
	// a hung handshake ends the run
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic axi_write(input logic [6:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axi_read(input logic [6:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		got = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] e);
		axi_read(a);
		cmp(got, e);
	endtask
	task automatic wait_irq();
		for (int k = 0; k < 20 && irq !== 1'b1; k++) @(posedge aclk);
		cmp({31'h0, irq}, 32'h1);
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(7'h10, 32'h0);
		rd_chk(7'h14, 32'h0);
		foreach (rows[i]) begin
			if (rows[i].wr) axi_write(rows[i].addr, rows[i].data);
			else rd_chk(rows[i].addr, rows[i].data);
		end
		$display("register table done");
		cmp(pins_oe, 32'h00ff_ff00);
		cmp(pins_o, 32'h0000_5a00);
		axi_write(7'h10, 32'h0);
		rd_chk(7'h04, 32'h0);
		field_en <= 32'h00ff_ffff;
		rd_chk(7'h0c, 32'hff);
		field_en <= 32'hffff_ffff;
		cmp(pins_o, 32'h0000_5a00);
		axi_read(7'h2c);
		cmp({30'h0, resp}, {30'h0, qpdio_pkg::RESP_SLVERR});
		$display("direction and map done");
		// start each mode at the idle level, then give it its trigger
		for (int m = 0; m < 4; m++) begin
			md = 2'(m);
			axi_write(7'h14, 32'h0);
			field_drv[0] <= ~md[0];
			axi_write(7'h14, {24'h0, 1'b1, 5'h0, md});
			rd_chk(7'h14, {24'h0, 1'b1, 5'h0, md});
			field_drv[0] <= md[0];
			wait_irq();
			rd_chk(7'h14, {24'h0, 2'h3, 4'h0, md});
			field_drv[0] <= ~md[0];
			if (!md[1]) rd_chk(7'h14, {24'h0, 2'h3, 4'h0, md});
			rd_chk(7'h14, {24'h0, 1'b1, 5'h0, md});
			cmp({31'h0, irq}, 32'h0);
		end
		rd_chk(7'h20, 32'h1);
		axi_write(7'h28, 32'h1);
		wait_irq();
		axi_write(7'h24, 32'h1);
		repeat (2) @(posedge aclk);
		cmp({31'h0, irq}, 32'h0);
		$display("interrupt modes done");
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cmp(pins_oe, 32'h0);
		rd_chk(7'h14, 32'h0);
		$display("second reset done");
		give_verdict();
	end
endmodule // test_quad_port_digital_io
